// [bench/por_brownout_tb.sv]
// self-checking bench for the power-on reset and brownout block
// assumes the board model on the reset pin and a short warmup
`timescale 1ns/1ps
`default_nettype none
module por_brownout_tb;
  import por_pkg::*;
  localparam int unsigned WM = 8;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic aboveOn = 1'b0, belowRst = 1'b0, rcStable = 1'b1, pinLvl;
  por_mon_t below = MON_NONE, flagClr = MON_NONE, irqEn = MON_NONE;
  por_mon_t irqReq;
  logic pinOut, pinOe, pwrEnWr = 1'b0, porFlagClr = 1'b0, holdLow = 1'b1;
  logic gMask = 1'b0, gEn = 1'b0, porFlag, cpuRun, fetchStart;
  logic [15:0] pwrEnWrData = 16'h0000, pwrEnRd, statusRd, fetchAddr;
  int errors = 0;
  int checksDone = 0;

  por_brownout #(.WARMUP(WM)) i_por_brownout (
    .clk(clk), .srst(srst), .coreAboveOnLvl(aboveOn),
    .coreBelowResetLvl(belowRst), .belowBrownoutLvl(below),
    .rcStable(rcStable), .rstPinIn(pinLvl), .rstPinOut(pinOut),
    .rstPinOe(pinOe), .pwrEnWrite(pwrEnWr), .pwrEnWrData(pwrEnWrData),
    .pwrEnRd(pwrEnRd), .statusRd(statusRd), .flagClr(flagClr),
    .porFlag(porFlag), .porFlagClr(porFlagClr), .irqEnable(irqEn),
    .moduleGroup5Mask(gMask), .globalIrqEnable(gEn), .irqReq(irqReq),
    .cpuRun(cpuRun), .fetchStart(fetchStart), .fetchAddr(fetchAddr)
  );
  por_ext_board i_por_ext_board (
    .rstPinOe(pinOe), .rstPinOut(pinOut), .holdLow(holdLow),
    .rstPinLvl(pinLvl)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // bounded wait on cpuRun (sel=1) or pin drive (sel=0)
  task automatic wait_lvl(input bit sel, input logic lvl);
    int i;
    for (i = 0; i < 200 && (sel ? cpuRun : pinOe) !== lvl; i++) begin
      tick(1);
    end
    chk(sel ? cpuRun : pinOe, lvl);
  endtask : wait_lvl

  task automatic pwr_write(input logic [15:0] d);
    @(posedge clk);
    pwrEnWr <= 1'b1;
    pwrEnWrData <= d;
    @(posedge clk);
    pwrEnWr <= 1'b0;
    tick(1);
  endtask : pwr_write

  task automatic wrap_up;
    $display("errors=%0d checks=%0d", errors, checksDone);
    if (errors == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    tick(2);
    chk(pinOe, 1'b1);
    chk(pinOut, 1'b0);
    chk(pwrEnRd, 16'h0080);
    chk(statusRd, 16'h0000);
    chk(porFlag, 1'b1);
    chk(cpuRun, 1'b0);
    // supply rises, dips early, rises again
    @(posedge clk);
    aboveOn <= 1'b1;
    repeat (6) @(posedge clk);
    aboveOn <= 1'b0;
    repeat (4) @(posedge clk);
    aboveOn <= 1'b1;
    tick(WM + 2);
    chk(pinOe, 1'b1);
    wait_lvl(1'b0, 1'b0);
    tick(20);
    chk(cpuRun, 1'b0);
    @(posedge clk);
    holdLow <= 1'b0;
    wait_lvl(1'b1, 1'b1);
    chk(fetchStart, 1'b1);
    chk(fetchAddr, 16'h8000);
    tick(1);
    chk(fetchStart, 1'b0);
    // enable all monitors, clear power-on flag
    pwr_write(16'h01e0);
    chk(pwrEnRd, 16'h01e0);
    @(posedge clk);
    porFlagClr <= 1'b1;
    @(posedge clk);
    porFlagClr <= 1'b0;
    tick(1);
    chk(porFlag, 1'b0);
    // brownout on all supplies, interrupt masked
    @(posedge clk);
    irqEn <= por_mon_t'(3'b111);
    below <= por_mon_t'(3'b111);
    tick(5);
    chk(statusRd, 16'h0070);
    chk(irqReq, 3'b000);
    @(posedge clk);
    gMask <= 1'b1;
    tick(3);
    chk(irqReq, 3'b000);
    @(posedge clk);
    gEn <= 1'b1;
    tick(3);
    chk(irqReq, 3'b111);
    // clear while still detecting: set wins
    @(posedge clk);
    flagClr <= por_mon_t'(3'b111);
    @(posedge clk);
    flagClr <= MON_NONE;
    tick(1);
    chk(statusRd, 16'h0070);
    // levels gone and through the synchroniser, then clear
    @(posedge clk);
    below <= MON_NONE;
    repeat (3) @(posedge clk);
    flagClr <= por_mon_t'(3'b111);
    @(posedge clk);
    flagClr <= MON_NONE;
    tick(2);
    chk(statusRd, 16'h0000);
    chk(irqReq, 3'b000);
    // outside hold in run: back to reset, power-on flag kept
    @(posedge clk);
    holdLow <= 1'b1;
    tick(4);
    chk(cpuRun, 1'b0);
    chk(porFlag, 1'b0);
    chk(pwrEnRd, 16'h0080);
    @(posedge clk);
    holdLow <= 1'b0;
    wait_lvl(1'b1, 1'b1);
    chk(fetchStart, 1'b1);
    // monitors off: no flags
    pwr_write(16'h0080);
    @(posedge clk);
    below <= por_mon_t'(3'b111);
    tick(6);
    chk(statusRd, 16'h0000);
    chk(irqReq, 3'b000);
    // supervisor off: deep fall ignored
    pwr_write(16'h0000);
    @(posedge clk);
    below <= MON_NONE;
    belowRst <= 1'b1;
    tick(5);
    chk(cpuRun, 1'b1);
    chk(porFlag, 1'b0);
    // supervisor on again: the same fall, still present, trips the reset
    pwr_write(16'h0080);
    tick(2);
    chk(pinOe, 1'b1);
    chk(cpuRun, 1'b0);
    chk(porFlag, 1'b1);
    tick(30);
    chk(pinOe, 1'b1);
    chk(pwrEnRd, 16'h0080);
    // recovery with an unstable oscillator: no count yet
    @(posedge clk);
    belowRst <= 1'b0;
    rcStable <= 1'b0;
    tick(WM + 10);
    chk(pinOe, 1'b1);
    @(posedge clk);
    rcStable <= 1'b1;
    wait_lvl(1'b1, 1'b1);
    chk(fetchAddr, 16'h8000);
    wrap_up();
  end
endmodule : por_brownout_tb
`default_nettype wire

// [bench/por_ext_board.sv]
// board side of the shared reset pin: pullup plus a switch to ground
// assumes the device drives the pin low only while rstPinOe is high
`timescale 1ns/1ps
`default_nettype none
module por_ext_board (
  // device drive
  input wire logic rstPinOe,
  input wire logic rstPinOut,
  // board control
  input wire logic holdLow,
  // wire level
  output logic rstPinLvl
);
  // wired-and, pullup when nobody pulls down
  assign rstPinLvl = !((rstPinOe && !rstPinOut) || holdLow);
endmodule : por_ext_board
`default_nettype wire

// [design/por_brownout.sv]
// power-on reset sequencing and supply brownout supervision
// assumes srst is the analog power-up pulse, clk the rc oscillator, and
// the reset pin is open drain with an external pullup
// Operation
// [R01] Power-up forces the supervisor enable to one, drives the pin low and resets all registers.
// [R02] Crossing the power-on level starts the warmup count while the pin stays low.
// [R03] The pin is released only after 65,536 stable oscillator cycles and while the supply is still good.
// [R04] Once the released pin reads high, fetch starts at address 8000h.
// [R05] Outside circuitry may hold the shared pin low, and the device stays in reset while it does.
// [R06] The power-on flag is set after every power-on or brownout reset.
// [R07] Software should clear the power-on flag after reading it.
// [R08] A core brownout reset drives the pin low and holds reset until the supply recovers.
// [R09] Each of the three supply monitors works only while its enable bit is set.
// [R10] An enabled core monitor records an event when the core supply drops below its level.
// [R11] A core brownout interrupt needs its enable, the group five mask and the global enable.
// [R12] A further fall below the reset level ends operation and holds power-on reset.
// [R13] Each brownout flag is set on detection, core at bit 5, io at bit 6, analog at bit 4.
// [R14] Clearing the supervisor enable turns the supervisor off; it resets to one.
// [R15] Only power-on or brownout reset sets the power-on flag; other resets leave it.
// [R16] Analog comparator levels pass two flip-flops before any logic uses them.
// [R17] The warmup count restarts whenever the supply drops below the power-on level early.
`timescale 1ns/1ps
`default_nettype none
module por_brownout
  import por_pkg::*;
#(
  parameter int unsigned WARMUP = por_pkg::WARMUP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // analog comparator levels and stability
  input wire logic coreAboveOnLvl,
  input wire logic coreBelowResetLvl,
  input wire por_pkg::por_mon_t belowBrownoutLvl,
  input wire logic rcStable,
  // reset pin, open drain
  input wire logic rstPinIn,
  output logic rstPinOut,
  output logic rstPinOe,
  // analog power enable register access
  input wire logic pwrEnWrite,
  input wire logic [15:0] pwrEnWrData,
  output logic [15:0] pwrEnRd,
  // status flags and clears
  output logic [15:0] statusRd,
  input wire por_pkg::por_mon_t flagClr,
  // power-on flag of watchdog control
  output logic porFlag,
  input wire logic porFlagClr,
  // interrupt gating
  input wire por_pkg::por_mon_t irqEnable,
  input wire logic moduleGroup5Mask,
  input wire logic globalIrqEnable,
  output var por_pkg::por_mon_t irqReq,
  // core start
  output logic cpuRun,
  output logic fetchStart,
  output logic [15:0] fetchAddr
);

  import por_pkg::*;

  // monitor enables out of the power enable image
  function automatic por_mon_t monEnables(input logic [15:0] img);
    por_mon_t m;
    m.io = img[PWREN_IO_BO_BIT];
    m.core = img[PWREN_CORE_BO_BIT];
    m.ana = img[PWREN_ANA_BO_BIT];
    return m;
  endfunction : monEnables

  // flags into status register positions
  function automatic logic [15:0] flagsToStatus(input por_mon_t f);
    logic [15:0] a;
    a = STAT_RESET;
    a[STAT_IO_BIT] = f.io;
    a[STAT_CORE_BIT] = f.core;
    a[STAT_ANA_BIT] = f.ana;
    return a;
  endfunction : flagsToStatus

  por_async_t asyncIn;
  por_async_t syncIn;
  logic cntDone;
  logic cntClear;
  logic cntEnable;
  logic supTrip;
  por_mon_t monEn;
  por_mon_t detect;

  por_state_t state_r;
  por_state_t state_nxt;
  logic [15:0] pwrEn_r;
  logic [15:0] pwrEn_nxt;
  por_mon_t flags_r;
  por_mon_t flags_nxt;
  por_mon_t irq_r;
  por_mon_t irq_nxt;
  logic porFlag_r;
  logic porFlag_nxt;
  logic pinOe_r;
  logic pinOe_nxt;
  logic cpuRun_r;
  logic cpuRun_nxt;
  logic fetchStart_r;
  logic fetchStart_nxt;
  logic [15:0] fetchAddr_r;
  logic [15:0] fetchAddr_nxt;
  logic pinOut_r;

  assign asyncIn.aboveOn = coreAboveOnLvl;
  assign asyncIn.belowReset = coreBelowResetLvl;
  assign asyncIn.below = belowBrownoutLvl;
  assign asyncIn.rcStable = rcStable;
  assign asyncIn.pin = rstPinIn;

  // all analog levels and the pin cross in before use
  por_sync2 #(.W($bits(por_async_t))) i_por_sync2 ( // R16
    .clk(clk),
    .srst(srst),
    .din(asyncIn),
    .dout(syncIn)
  );

  // counter restarts outside warmup, runs only on a stable oscillator
  assign cntClear = (state_r != ST_WARM) || !syncIn.aboveOn; // R17
  assign cntEnable = syncIn.rcStable; // R03

  por_warmup_cnt #(.CYCLES(WARMUP)) i_por_warmup_cnt (
    .clk(clk),
    .srst(srst),
    .clear(cntClear),
    .enable(cntEnable),
    .done(cntDone)
  );

  assign monEn = monEnables(pwrEn_r);
  assign detect = syncIn.below & monEn; // R09 R10

  // supervisor trips on a fall below the reset level when enabled
  assign supTrip = pwrEn_r[PWREN_SUP_BIT] && syncIn.belowReset; // R12 R14

  always_comb begin
    state_nxt = state_r;
    pwrEn_nxt = pwrEn_r;
    porFlag_nxt = porFlag_r;
    fetchStart_nxt = 1'b0;
    fetchAddr_nxt = fetchAddr_r;
    flags_nxt = (flags_r & ~flagClr) | detect; // R13
    case (state_r)
      ST_OFF: begin
        if (syncIn.aboveOn && !syncIn.belowReset) begin
          state_nxt = ST_WARM; // R02
        end
      end
      ST_WARM: begin
        if (!syncIn.aboveOn) begin
          state_nxt = ST_OFF; // R17
        end else if (cntDone) begin
          state_nxt = ST_REL; // R03
        end
      end
      ST_REL: begin
        if (syncIn.pin) begin
          state_nxt = ST_RUN; // R05
          fetchStart_nxt = 1'b1; // R04
          fetchAddr_nxt = RESET_VECTOR;
        end
      end
      ST_RUN: begin
        if (!syncIn.pin) begin
          // pin reset: power enable back to reset, status flags and power-on flag kept
          state_nxt = ST_REL; // R05 R15
          pwrEn_nxt = PWREN_RESET;
        end else begin
          if (pwrEnWrite) begin
            pwrEn_nxt = (pwrEnWrData & PWREN_RW_MASK); // R14
          end
          if (porFlagClr) begin
            porFlag_nxt = 1'b0;
          end
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    if (state_r == ST_OFF) begin
      flags_nxt = MON_NONE;
    end
    // brownout reset overrides any write or clear
    if (supTrip) begin
      state_nxt = ST_OFF; // R08 R12
      porFlag_nxt = 1'b1; // R06
      pwrEn_nxt = PWREN_RESET; // R01
      flags_nxt = MON_NONE;
    end
    pinOe_nxt = (state_nxt == ST_OFF) || (state_nxt == ST_WARM); // R02 R08
    cpuRun_nxt = (state_nxt == ST_RUN); // R05
    irq_nxt = MON_NONE;
    if (cpuRun_nxt && moduleGroup5Mask && globalIrqEnable) begin
      irq_nxt = flags_nxt & irqEnable; // R11
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_OFF; // R01
      pwrEn_r <= PWREN_RESET; // R01 R14
      flags_r <= MON_NONE;
      irq_r <= MON_NONE;
      porFlag_r <= 1'b1; // R06
      pinOe_r <= 1'b1; // R01
      cpuRun_r <= 1'b0;
      fetchStart_r <= 1'b0;
      fetchAddr_r <= RESET_VECTOR;
      pinOut_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pwrEn_r <= pwrEn_nxt;
      flags_r <= flags_nxt;
      irq_r <= irq_nxt;
      porFlag_r <= porFlag_nxt;
      pinOe_r <= pinOe_nxt;
      cpuRun_r <= cpuRun_nxt;
      fetchStart_r <= fetchStart_nxt;
      fetchAddr_r <= fetchAddr_nxt;
      pinOut_r <= 1'b0;
    end
  end

  assign rstPinOut = pinOut_r;
  assign rstPinOe = pinOe_r;
  assign pwrEnRd = pwrEn_r;
  assign statusRd = flagsToStatus(flags_r);
  assign porFlag = porFlag_r;
  assign irqReq = irq_r;
  assign cpuRun = cpuRun_r;
  assign fetchStart = fetchStart_r;
  assign fetchAddr = fetchAddr_r;

  // checks next to the sequencing logic
  property p_powerUp;
    @(posedge clk) srst |=> rstPinOe && pwrEnRd == PWREN_RESET && !cpuRun;
  endproperty
  a_powerUp: assert property (p_powerUp) // R01
    else $error("power-up did not hold reset state");

  property p_warmHold;
    @(posedge clk) disable iff (srst) state_r == ST_WARM |-> rstPinOe;
  endproperty
  a_warmHold: assert property (p_warmHold) // R02
    else $error("pin released during warmup");

  property p_release;
    @(posedge clk) disable iff (srst)
      $fell(rstPinOe) |-> $past(cntDone) && $past(syncIn.aboveOn);
  endproperty
  a_release: assert property (p_release) // R03
    else $error("pin released before warmup end");

  property p_vector;
    @(posedge clk) disable iff (srst)
      $rose(cpuRun) |-> fetchStart && fetchAddr == RESET_VECTOR;
  endproperty
  a_vector: assert property (p_vector) // R04
    else $error("fetch not started at reset vector");

  property p_pinHold;
    @(posedge clk) disable iff (srst) !syncIn.pin |=> !cpuRun;
  endproperty
  a_pinHold: assert property (p_pinHold) // R05
    else $error("running while reset pin low");

  property p_borFlag;
    @(posedge clk) disable iff (srst)
      supTrip |=> porFlag && rstPinOe && !cpuRun ##1 rstPinOe;
  endproperty
  a_borFlag: assert property (p_borFlag) // R06
    else $error("brownout reset not entered");

  property p_flagSet;
    @(posedge clk) disable iff (srst)
      syncIn.below.core && monEn.core && !supTrip && state_r != ST_OFF
      |=> statusRd[STAT_CORE_BIT];
  endproperty
  a_flagSet: assert property (p_flagSet) // R13
    else $error("core brownout flag not set");

  property p_irqGate;
    @(posedge clk) disable iff (srst)
      irqReq.core |-> $past(moduleGroup5Mask) && $past(globalIrqEnable)
      && $past(irqEnable.core);
  endproperty
  a_irqGate: assert property (p_irqGate) // R11
    else $error("core interrupt raised without enables");

  property p_keepPor;
    @(posedge clk) disable iff (srst)
      state_r == ST_RUN && !syncIn.pin && !supTrip
      |=> porFlag == $past(porFlag);
  endproperty
  a_keepPor: assert property (p_keepPor) // R15
    else $error("pin reset changed power-on flag");

  property p_restart;
    @(posedge clk) disable iff (srst)
      state_r == ST_WARM && !syncIn.aboveOn |=> state_r == ST_OFF && !cntDone;
  endproperty
  a_restart: assert property (p_restart) // R17
    else $error("warmup not restarted on supply drop");

endmodule : por_brownout
`default_nettype wire

// [design/por_pkg.sv]
// constants and carrier types for the power-on reset and brownout block
// assumes a single 200 MHz clock, which is also the warmup count clock
package por_pkg;

  // reset vector where fetch starts after any reset
  localparam logic [15:0] RESET_VECTOR = 16'h8000;

  // warmup length in oscillator cycles
  localparam int unsigned WARMUP_CYCLES = 65536;

  // analog power enable register layout
  localparam int PWREN_IO_BO_BIT = 8;
  localparam int PWREN_SUP_BIT = 7;
  localparam int PWREN_CORE_BO_BIT = 6;
  localparam int PWREN_ANA_BO_BIT = 5;
  localparam logic [15:0] PWREN_RESET = 16'h0080;
  localparam logic [15:0] PWREN_RW_MASK = 16'h01e0;

  // analog status register flag positions
  localparam int STAT_IO_BIT = 6;
  localparam int STAT_CORE_BIT = 5;
  localparam int STAT_ANA_BIT = 4;
  localparam logic [15:0] STAT_RESET = 16'h0000;

  // one bit for each of the three supply monitors
  typedef struct packed {
    logic io;
    logic core;
    logic ana;
  } por_mon_t;

  localparam por_mon_t MON_NONE = '{io: 1'b0, core: 1'b0, ana: 1'b0};

  // levels arriving from the analog cells and the reset pin
  typedef struct packed {
    logic aboveOn;
    logic belowReset;
    por_mon_t below;
    logic rcStable;
    logic pin;
  } por_async_t;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_WARM = 4'b0010,
    ST_REL = 4'b0100,
    ST_RUN = 4'b1000
  } por_state_t;

endpackage : por_pkg

// [design/por_sync2.sv]
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level; no word coherence is given
`timescale 1ns/1ps
`default_nettype none
module por_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_r;
  logic [W-1:0] dout_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      dout_r <= '0;
    end else begin
      meta_r <= din;
      dout_r <= meta_r;
    end
  end

  assign dout = dout_r;

endmodule : por_sync2
`default_nettype wire

// [design/por_warmup_cnt.sv]
// warmup counter: counts enabled cycles up to a fixed length
// assumes clear and enable come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module por_warmup_cnt #(
  parameter int unsigned CYCLES = 65536
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic clear,
  input wire logic enable,
  // status
  output logic done
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES);

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    count_nxt = count_r;
    if (clear) begin
      count_nxt = '0;
    end else if (enable && count_r != LAST) begin
      count_nxt = count_r + CW'(1);
    end
    done_nxt = (count_nxt == LAST);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count_r <= '0;
      done_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;

endmodule : por_warmup_cnt
`default_nettype wire
